//--- bench/lsg_link_props.sv
`timescale 1ns/100ps
`default_nettype none
module lsg_link_props
  import lsg_pkg::*;
#(
  parameter int HALF_CYC  = PWM_HALF,
  parameter int LATCH_LEN = LATCH_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic pwmClock,
  input wire logic latchStrobe,
  input wire logic shiftEdgeSelect
);
  logic       strobeAct;
  logic [7:0] actCnt_reg;
  logic [7:0] actCnt_next;
  logic [7:0] hiCnt_reg;
  logic [7:0] hiCnt_next;

  // Active level flips with edge select
  assign strobeAct   = latchStrobe ^ shiftEdgeSelect;
  assign actCnt_next = strobeAct ? actCnt_reg + 8'h01 : 8'h00;
  assign hiCnt_next  = pwmClock ? hiCnt_reg + 8'h01 : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      actCnt_reg <= 8'h00;
      hiCnt_reg  <= 8'h00;
    end else begin
      actCnt_reg <= actCnt_next;
      hiCnt_reg  <= hiCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sStrobeStart; $rose(strobeAct); endsequence
  sequence sStrobeEnd;   $fell(strobeAct); endsequence
  sequence sPwmRise;     $rose(pwmClock);  endsequence

  a_strobe_length: assert property (sStrobeEnd |-> actCnt_reg == 8'(LATCH_LEN))
    else $error("strobe length wrong");
  a_strobe_bounded: assert property (sStrobeStart |-> ##[1:64] !strobeAct)
    else $error("strobe never ends");
  a_strobe_pwm_low: assert property (strobeAct |-> !pwmClock)
    else $error("pwm clock high during strobe");
  a_strobe_from_low: assert property (sStrobeStart |-> !$past(pwmClock))
    else $error("strobe started while pwm high");
  a_strobe_end_low: assert property (sStrobeEnd |-> !pwmClock)
    else $error("strobe ended with pwm high");
  a_pwm_high_max: assert property (hiCnt_reg >= 8'(HALF_CYC) |-> !pwmClock)
    else $error("pwm high phase too long");
  a_pwm_high_min: assert property (sPwmRise |-> pwmClock [*3])
    else $error("pwm high phase too short");
  a_pwm_low_min: assert property ($fell(pwmClock) |-> !pwmClock [*3])
    else $error("pwm low phase too short");
endmodule
`default_nettype wire

//--- bench/tb_led_sink_grayscale_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module tb_led_sink_grayscale_pwm;
  import lsg_pkg::*;
  localparam int HC = 3;
  localparam int LL = 8;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      cyc = 1'b0;
  logic                      stb = 1'b0;
  logic                      we = 1'b0;
  logic [7:0]                adr = 8'h00;
  logic [31:0]               wdat = 32'h0;
  logic [3:0]                sel = 4'h0;
  logic [31:0]               rdat;
  logic                      ack;
  logic [CH_NUM-1:0]         sinkOn;
  logic [CH_NUM*LEVEL_W-1:0] sinkLevel;
  logic                      measDone = 1'b0;
  logic                      clrCnt = 1'b0;
  logic [31:0]               rdQ[$];
  logic [31:0]               outQ[$];
  int                        onCnt[CH_NUM];
  int                        nErrors = 0;
  int                        samplesChecked = 0;

  lsg_link_if link();
  lsg_host #(.HALF_CYC(HC), .LATCH_LEN(LL), .STAGE_ODD(1'b0)) i_lsg_host (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
  lsg_device i_lsg_device (
    .clk(clk), .rst(rst), .link(link), .sinkOn(sinkOn), .sinkLevel(sinkLevel));
  lsg_link_props #(.HALF_CYC(HC), .LATCH_LEN(LL)) i_lsg_link_props (
    .clk(clk), .rst(rst), .pwmClock(link.pwmClock), .latchStrobe(link.latchStrobe),
    .shiftEdgeSelect(link.shiftEdgeSelect));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmpRd(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpOut(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until ack; gives up and ends the run after 50 clocks
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      nErrors++;
      endSim();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wbRead(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    wbCycle(1'b0, a, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: read data at ack, output tallies at measDone
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) cmpRd(rdat, rdQ.pop_front());
    if (measDone === 1'b1) begin
      for (int i = 0; i < CH_NUM; i++) cmpOut(32'(onCnt[i]), outQ.pop_front());
      for (int i = 0; i < CH_NUM; i++) cmpOut({16'h0, sinkLevel[16*i +: 16]}, outQ.pop_front());
      cmpOut({16'h0, link.grayWord[31:16]}, outQ.pop_front());
    end
    for (int i = 0; i < CH_NUM; i++) begin
      if (clrCnt) onCnt[i] = 0;
      else if (sinkOn[i] === 1'b1) onCnt[i]++;
    end
  end

  // Window must outlast the longest on-time, gray kept small for that
  task automatic runFrame(input logic [31:0] ctrl, input logic split);
    logic [7:0]  g[COLOURS];
    logic [6:0]  t[CH_NUM];
    logic [15:0] gy[CH_NUM];
    logic [15:0] m;
    m = split ? 16'hFFF0 : 16'hFFFF;
    for (int i = 0; i < COLOURS; i++) g[i] = 8'($urandom_range(255));
    wbCycle(1'b1, ADR_GAIN, {8'h00, g[2], g[1], g[0]});
    wbRead(ADR_GAIN, {8'h00, g[2], g[1], g[0]});
    for (int i = 0; i < CH_NUM; i++) begin
      t[i] = (i == 1) ? 7'h7F : 7'($urandom_range(127));
      gy[i] = (i == 0) ? 16'h0 : 16'($urandom_range(split ? 319 : 8191));
      wbCycle(1'b1, ADR_TRIM_BASE + 8'(4*i), {25'h0, t[i]});
      wbCycle(1'b1, ADR_GRAY_BASE + 8'(4*i), {16'h0, gy[i]});
    end
    wbCycle(1'b1, ADR_CTRL, ctrl);
    clrCnt <= 1'b1;
    wbCycle(1'b1, ADR_CMD, 32'h1);
    clrCnt <= 1'b0;
    repeat (2000) @(posedge clk);
    wbCycle(1'b1, ADR_CTRL, ctrl & ~32'h10);
    repeat (20) @(posedge clk);
    for (int i = 0; i < CH_NUM; i++) begin
      if (split) outQ.push_back(32'(gy[i] & m) * 32'(2*HC));
      else outQ.push_back(((32'(gy[i]) + 32'h1F) >> 5) * 32'(2*HC));
    end
    for (int i = 0; i < CH_NUM; i++)
      outQ.push_back((32'(g[i%COLOURS]) + 32'h1) * (32'(t[i]) + 32'h1));
    outQ.push_back({16'h0, gy[1] & m});
    measDone <= 1'b1;
    @(posedge clk);
    measDone <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    #200_000;
    nErrors++;
    endSim();
  end

  initial begin
    void'($urandom(32'h06E0));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wbRead(ADR_CTRL, CTRL_RESET);
    wbRead(ADR_FRAME, 32'h0);
    wbRead(8'hFC, 32'h0);
    runFrame(32'h0000_0C15, 1'b1);
    runFrame(32'h0000_1012, 1'b0);
    repeat (4) @(posedge clk);
    endSim();
  end
endmodule
`default_nettype wire

//--- design/lsg_device.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module lsg_device
  import lsg_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  lsg_link_if.device                     link,
  output var  logic [CH_NUM-1:0]         sinkOn,
  output var  logic [CH_NUM*LEVEL_W-1:0] sinkLevel
);

  // Product fits 16 bits: 256*128 is the full-scale code
  function automatic logic [LEVEL_W-1:0] sinkScale(
    input logic [GAIN_W-1:0] gain,
    input logic [TRIM_W-1:0] trim
  );
    logic [LEVEL_W-1:0] g1;
    logic [LEVEL_W-1:0] t1;
    g1 = {8'h00, gain} + 16'h0001;
    t1 = {9'h000, trim} + 16'h0001;
    return LEVEL_W'(g1 * t1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [PIN_W-1:0] syncA_reg;
  logic [PIN_W-1:0] syncB_reg;
  logic [PIN_W-1:0] syncC_reg;
  logic [PIN_W-1:0] clean_reg;
  logic [PIN_W-1:0] clean_next;
  logic             pwmPrev_reg;
  wire  logic [PIN_W-1:0] pinIn;

  assign pinIn = {link.singlePeriodEnable, link.waveSplitSelect,
                  link.shiftEdgeSelect, link.latchStrobe, link.pwmClock};

  // A level counts only once two stages agree
  assign clean_next = (syncB_reg & syncC_reg) | (clean_reg & (syncB_reg | syncC_reg));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg   <= 5'h00;
      syncB_reg   <= 5'h00;
      syncC_reg   <= 5'h00;
      clean_reg   <= 5'h00;
      pwmPrev_reg <= 1'b0;
    end else begin
      syncA_reg   <= pinIn;
      syncB_reg   <= syncA_reg;
      syncC_reg   <= syncB_reg;
      clean_reg   <= clean_next;
      pwmPrev_reg <= clean_reg[0];
    end
  end

  wire logic pwmLevel;
  wire logic latchLevel;
  wire logic edgeSelect;
  wire logic splitSelect;
  wire logic oneShotOn;
  wire logic strobeActive;
  wire logic pwmRise;

  assign pwmLevel    = clean_reg[0];
  assign latchLevel  = clean_reg[1];
  assign edgeSelect  = clean_reg[2];
  assign splitSelect = clean_reg[3];
  assign oneShotOn   = clean_reg[4];

  // Strobe polarity follows the edge select strap
  assign strobeActive = latchLevel ^ edgeSelect;
  assign pwmRise      = pwmLevel & ~pwmPrev_reg;

  // PWM phases shorter than two clocks can be filtered
  // away by the agreement check; the host keeps them longer

  ////////////////////////////////////////////////////////////////////////////////
  // Data latches, transparent while the strobe is active

  logic [GS_W-1:0]   gray_reg [CH_NUM];
  logic [TRIM_W-1:0] trim_reg [CH_NUM];
  logic [GAIN_W-1:0] gain_reg [COLOURS];

  // Words come from logic on this clock, so they skip the
  // synchroniser; the host does not hold them, so writes during the strobe reach the latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CH_NUM; i++) begin
        gray_reg[i] <= 16'h0000;
        trim_reg[i] <= 7'h00;
      end
      for (int k = 0; k < COLOURS; k++) begin
        gain_reg[k] <= 8'h00;
      end
    end else if (strobeActive) begin
      for (int i = 0; i < CH_NUM; i++) begin
        gray_reg[i] <= link.grayWord[i*GS_W +: GS_W];
        trim_reg[i] <= link.trimWord[i*TRIM_W +: TRIM_W];
      end
      for (int k = 0; k < COLOURS; k++) begin
        gain_reg[k] <= link.gainWord[k*GAIN_W +: GAIN_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PWM counter and one-shot tracking

  logic [GS_W-1:0] cnt_reg;
  logic [GS_W-1:0] cnt_next;
  logic            run_reg;
  logic            done_reg;
  logic            done_next;
  logic            armed_reg;
  wire  logic      periodEnd;

  // Period ends when a started count wraps from all ones
  assign periodEnd = run_reg & (cnt_reg == CNT_ALL_ONES);
  assign cnt_next  = strobeActive ? CNT_ALL_ONES
                   : pwmRise      ? GS_W'(cnt_reg + 16'h0001)
                   : cnt_reg;
  // A new strobe clears the one-shot end, so a strobe in
  // mid-period restarts a full period
  assign done_next = strobeActive ? 1'b0
                   : (pwmRise & periodEnd) ? 1'b1
                   : done_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= CNT_ALL_ONES;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      run_reg  <= strobeActive ? 1'b0 : (run_reg | pwmRise);
      done_reg <= done_next;
    end
  end

  // Nothing is trusted before a first strobe, so outputs stay dark
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (strobeActive) begin
      armed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and current scaling

  localparam int LOW_W = GS_W - SECT_BITS;

  wire logic [GS_W-1:0]         rotCmp;
  wire logic [GS_W-1:0]         cmpVal;
  wire logic                    gateOn;
  wire logic [CH_NUM-1:0]       onNext;
  wire logic [CH_NUM*LEVEL_W-1:0] levelNext;

  // Section index in the top bits, slot inside the section below it;
  // the rotation is a bijection, so total on-time is unchanged
  assign rotCmp = {cnt_reg[LOW_W-1:0], cnt_reg[GS_W-1:LOW_W]};
  assign cmpVal = splitSelect ? cnt_reg : rotCmp;
  assign gateOn = armed_reg & ~(oneShotOn & done_reg);

  // Current code follows the latches, so a new gain or trim
  // shows one clock after the strobe has latched it
  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : gCh
      assign onNext[c] = gateOn & (gray_reg[c] > cmpVal);
      assign levelNext[c*LEVEL_W +: LEVEL_W] =
        sinkScale(gain_reg[c % COLOURS], trim_reg[c]);
    end
  endgenerate

  // Registered so the sinks never see decode glitches
  // from the compare and the scaling product
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinkOn    <= 24'h000000;
      sinkLevel <= '0;
    end else begin
      sinkOn    <= onNext;
      sinkLevel <= levelNext;
    end
  end

endmodule
`default_nettype wire

//--- design/lsg_host.sv
`timescale 1ns/100ps
`default_nettype none
module lsg_host
  import lsg_pkg::*;
#(
  parameter int         HALF_CYC  = PWM_HALF,
  parameter int         LATCH_LEN = LATCH_CYC,
  parameter logic       STAGE_ODD = 1'b0
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  lsg_link_if.host         link
);

  function automatic logic [31:0] applySel(
    input logic [31:0] oldV,
    input logic [31:0] newV,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = oldV;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = newV[b*8 +: 8];
    end
    return r;
  endfunction

  // Depth n keeps the top n bits; out-of-range depth means full 16
  function automatic logic [GS_W-1:0] grayMask(input logic [DEPTH_W-1:0] depth);
    logic [GS_W-1:0] m;
    m = 16'hFFFF;
    if (depth != 5'h00 && depth < 5'h10) m = 16'hFFFF << (5'h10 - depth);
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic [31:0]       ctrl_reg;
  logic [16:0]       frame_reg;
  logic [23:0]       gain_reg;
  logic [TRIM_W-1:0] trim_reg [CH_NUM];
  logic [GS_W-1:0]   gray_reg [CH_NUM];
  logic              latchReq_reg;
  lsg_hstate_t       state_reg;
  logic [16:0]       edgeCnt_reg;

  wire logic       req;
  wire logic       wrEn;
  wire logic [7:0] trimOff;
  wire logic [7:0] grayOff;
  wire logic       trimHit;
  wire logic       grayHit;
  wire logic [4:0] trimIdx;
  wire logic [4:0] grayIdx;
  logic [31:0]     rdData;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrEn    = req & wb_we_i;
  assign trimOff = wb_adr_i - ADR_TRIM_BASE;
  assign grayOff = wb_adr_i - ADR_GRAY_BASE;
  assign trimHit = (wb_adr_i >= ADR_TRIM_BASE) && (trimOff[7:2] < 6'(CH_NUM));
  assign grayHit = (wb_adr_i >= ADR_GRAY_BASE) && (grayOff[7:2] < 6'(CH_NUM));
  assign trimIdx = trimOff[6:2];
  assign grayIdx = grayOff[6:2];

  always_comb begin
    rdData = 32'h0000_0000;
    if (wb_adr_i == ADR_CTRL) begin
      rdData = ctrl_reg;
    end else if (wb_adr_i == ADR_FRAME) begin
      rdData = {15'h0000, frame_reg};
    end else if (wb_adr_i == ADR_STATUS) begin
      rdData = {12'h000, latchReq_reg, state_reg, edgeCnt_reg};
    end else if (wb_adr_i == ADR_GAIN) begin
      rdData = {8'h00, gain_reg};
    end else if (trimHit) begin
      rdData = {25'h0000000, trim_reg[trimIdx]};
    end else if (grayHit) begin
      rdData = {16'h0000, gray_reg[grayIdx]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdData : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= CTRL_RESET;
      frame_reg <= FRAME_RESET;
      gain_reg  <= 24'h000000;
      for (int i = 0; i < CH_NUM; i++) begin
        trim_reg[i] <= 7'h00;
        gray_reg[i] <= 16'h0000;
      end
    end else if (wrEn) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl_reg <= applySel(ctrl_reg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_FRAME) begin
        frame_reg <= 17'(applySel({15'h0000, frame_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == ADR_GAIN) begin
        gain_reg <= 24'(applySel({8'h00, gain_reg}, wb_dat_i, wb_sel_i));
      end else if (trimHit) begin
        trim_reg[trimIdx] <= 7'(applySel({25'h0, trim_reg[trimIdx]}, wb_dat_i, wb_sel_i));
      end else if (grayHit) begin
        gray_reg[grayIdx] <= 16'(applySel({16'h0, gray_reg[grayIdx]}, wb_dat_i, wb_sel_i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sequencer

  wire logic cmdStrobe;
  wire logic runOn;
  wire logic edgeSel;
  wire logic [GS_W-1:0] mask;
  logic [15:0] div_reg;
  logic [15:0] latchCnt_reg;
  logic        pwm_reg;
  wire  logic  divTick;
  wire  logic  frameDone;

  assign cmdStrobe = wrEn & (wb_adr_i == ADR_CMD) & wb_sel_i[0] & wb_dat_i[0];
  assign runOn     = ctrl_reg[CTRL_RUN_BIT];
  assign edgeSel   = ctrl_reg[CTRL_EDGE_BIT] ^ (ctrl_reg[CTRL_CASCADE_BIT] & STAGE_ODD);
  assign mask      = grayMask(ctrl_reg[CTRL_DEPTH_LSB +: DEPTH_W]);
  assign divTick   = (div_reg == 16'(HALF_CYC - 1));
  assign frameDone = (frame_reg != 17'h00000) && (edgeCnt_reg >= frame_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= HS_LATCH;
      latchCnt_reg <= 16'h0000;
      latchReq_reg <= 1'b0;
      div_reg      <= 16'h0000;
      pwm_reg      <= 1'b0;
      edgeCnt_reg  <= 17'h00000;
    end else begin
      latchReq_reg <= (latchReq_reg | cmdStrobe) & ~(state_reg == HS_LATCH);
      div_reg      <= (state_reg != HS_RUN || divTick) ? 16'h0000 : 16'(div_reg + 16'h0001);
      case (state_reg)
        HS_IDLE: begin
          pwm_reg <= 1'b0;
          if (latchReq_reg | cmdStrobe) begin
            state_reg    <= HS_LATCH;
            latchCnt_reg <= 16'h0000;
          end else if (runOn) begin
            state_reg <= HS_RUN;
          end
        end
        HS_LATCH: begin
          pwm_reg      <= 1'b0;
          edgeCnt_reg  <= 17'h00000;
          latchCnt_reg <= 16'(latchCnt_reg + 16'h0001);
          if (latchCnt_reg == 16'(LATCH_LEN - 1)) begin
            state_reg <= runOn ? HS_RUN : HS_IDLE;
          end
        end
        HS_RUN: begin
          // Changes of state only while the PWM clock is low
          if (divTick) begin
            if (pwm_reg) begin
              pwm_reg <= 1'b0;
            end else if (latchReq_reg | frameDone) begin
              state_reg    <= HS_LATCH;
              latchCnt_reg <= 16'h0000;
            end else if (!runOn) begin
              state_reg <= HS_IDLE;
            end else begin
              pwm_reg     <= 1'b1;
              edgeCnt_reg <= 17'(edgeCnt_reg + 17'h00001);
            end
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link outputs, all registered

  logic [CH_NUM*GS_W-1:0]   grayOut_reg;
  logic [CH_NUM*TRIM_W-1:0] trimOut_reg;
  logic                     latchOut_reg;
  logic [2:0]               modeOut_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grayOut_reg  <= '0;
      trimOut_reg  <= '0;
      latchOut_reg <= 1'b0;
      modeOut_reg  <= 3'h0;
    end else begin
      for (int i = 0; i < CH_NUM; i++) begin
        grayOut_reg[i*GS_W +: GS_W]     <= gray_reg[i] & mask;
        trimOut_reg[i*TRIM_W +: TRIM_W] <= trim_reg[i];
      end
      latchOut_reg <= (state_reg == HS_LATCH) ^ edgeSel;
      modeOut_reg  <= {ctrl_reg[CTRL_ONESHOT_BIT], ctrl_reg[CTRL_SPLIT_BIT], edgeSel};
    end
  end

  assign link.pwmClock           = pwm_reg;
  assign link.latchStrobe        = latchOut_reg;
  assign link.shiftEdgeSelect    = modeOut_reg[0];
  assign link.waveSplitSelect    = modeOut_reg[1];
  assign link.singlePeriodEnable = modeOut_reg[2];
  assign link.grayWord           = grayOut_reg;
  assign link.gainWord           = gain_reg;
  assign link.trimWord           = trimOut_reg;

endmodule
`default_nettype wire

//--- design/lsg_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lsg_link_if
  import lsg_pkg::*;
();
  logic                        pwmClock;
  logic                        latchStrobe;
  logic                        shiftEdgeSelect;
  logic                        waveSplitSelect;
  logic                        singlePeriodEnable;
  logic [CH_NUM*GS_W-1:0]      grayWord;
  logic [COLOURS*GAIN_W-1:0]   gainWord;
  logic [CH_NUM*TRIM_W-1:0]    trimWord;

  modport host (
    output pwmClock, latchStrobe, shiftEdgeSelect, waveSplitSelect,
    output singlePeriodEnable, grayWord, gainWord, trimWord
  );
  modport device (
    input pwmClock, latchStrobe, shiftEdgeSelect, waveSplitSelect,
    input singlePeriodEnable, grayWord, gainWord, trimWord
  );
endinterface
`default_nettype wire

//--- design/lsg_pkg.sv
package lsg_pkg;
  localparam int CH_NUM    = 24;
  localparam int GS_W      = 16;
  localparam int GAIN_W    = 8;
  localparam int TRIM_W    = 7;
  localparam int COLOURS   = 3;
  localparam int SECT_BITS = 5;
  localparam int LEVEL_W   = 16;
  localparam int PIN_W     = 5;
  localparam logic [GS_W-1:0] CNT_ALL_ONES = 16'hFFFF;
  localparam int PERIOD_CLKS = 65536;

  localparam int CLK_NS      = 10;
  localparam int LATCH_NS    = 200;
  localparam int LATCH_CYC   = (LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWM_HALF_NS = 50;
  localparam int PWM_HALF    = PWM_HALF_NS / CLK_NS;

  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_CMD       = 8'h04;
  localparam logic [7:0] ADR_FRAME     = 8'h08;
  localparam logic [7:0] ADR_STATUS    = 8'h0C;
  localparam logic [7:0] ADR_GAIN      = 8'h10;
  localparam logic [7:0] ADR_TRIM_BASE = 8'h40;
  localparam logic [7:0] ADR_GRAY_BASE = 8'hA0;

  localparam int CTRL_SPLIT_BIT   = 0;
  localparam int CTRL_ONESHOT_BIT = 1;
  localparam int CTRL_EDGE_BIT    = 2;
  localparam int CTRL_CASCADE_BIT = 3;
  localparam int CTRL_RUN_BIT     = 4;
  localparam int CTRL_DEPTH_LSB   = 8;
  localparam int DEPTH_W          = 5;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_1001;
  localparam logic [16:0] FRAME_RESET = 17'h00000;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_LATCH = 2'b01,
    HS_RUN   = 2'b10
  } lsg_hstate_t;
endpackage

//--- design/README_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
